// File: core/fpc_ctrl.sv
// flash prefetch and cache control: control register, line valid state, wait states
// assumes an avalon-mm master on the register port and a core fetch port,
// both synchronous to clk
//
// Function
// - coherency set: program invalidates all lines
// - coherency clear: keep locked instruction lines
// - data size change invalidates every line
// - size field selects 0,1,2,4 data lines
// - prefetch field selects prefetched regions
// - wait-state field gives 0 to 7 waits
// - clear, set, invert aliases at 4,8,c
module fpc_ctrl
  import fpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // core fetch port
  input  wire logic        fetch_req,
  input  wire logic        fetch_is_data,
  input  wire logic        fetch_cacheable,
  input  wire logic        fetch_hit,
  input  wire logic [1:0]  fetch_line,
  input  wire logic        fetch_lock,
  output logic             fetch_stall,
  output logic             fetch_ready,
  // flash side
  input  wire logic        program_cycle,
  output logic             prefetch_enable,
  output logic [3:0]       line_valid,
  output logic [3:0]       data_line_enable
);

  // ************************************************************
  // register bus: one wait cycle, answer on the second edge
  // ************************************************************
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        bus_ack;
  logic        next_bus_ack;
  logic [31:0] next_readdata;
  logic        size_changed;

  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wval  = avs_writedata & wmask;
    next_ctrl = ctrl;
    next_bus_ack = (avs_read || avs_write) && !bus_ack;
    next_readdata = avs_readdata;
    // the write lands at the edge where the master sees waitrequest low
    if (avs_write && bus_ack) begin
      unique case (avs_address)
        FPC_CTRL_OFS: next_ctrl = (ctrl & ~wmask) | wval;
        FPC_CLR_OFS:  next_ctrl = ctrl & ~wval;
        FPC_SET_OFS:  next_ctrl = ctrl | wval;
        FPC_INV_OFS:  next_ctrl = ctrl ^ wval;
        default:      next_ctrl = ctrl;
      endcase
    end
    // unused bits never store, read zero whatever software wrote
    next_ctrl = next_ctrl & FPC_CTRL_MASK;
    if (avs_read && !bus_ack) begin
      // aliases and unmapped words read zero
      next_readdata = (avs_address == FPC_CTRL_OFS) ? ctrl : 32'h0000_0000;
    end
  end

  assign size_changed = (next_ctrl[FPC_DATA_CACHE_LINE_COUNT_POS +: 2] != ctrl[FPC_DATA_CACHE_LINE_COUNT_POS +: 2]);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl            <= FPC_CTRL_RESET;
      bus_ack         <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrl            <= next_ctrl;
      bus_ack         <= next_bus_ack;
      avs_readdata    <= next_readdata;
      // registered inverse of next_bus_ack, so the pin equals !bus_ack and comes straight from a flop
      avs_waitrequest <= !next_bus_ack;
    end
  end

  // ************************************************************
  // invalidation and line state
  // ************************************************************
  logic       coh;
  logic [1:0] data_cache_line_count;
  logic [3:0] data_en;
  logic       kill_all;
  logic       kill_unlocked;
  logic [3:0] valid_q;
  logic [3:0] locked_q;
  logic [3:0] fill;
  logic       timer_busy;
  logic       timer_done;
  logic       miss_start;
  logic [1:0] fetch_line_q;
  logic       data_q;
  logic       lock_q;
  logic [1:0] next_line_q;
  logic       next_data_q;
  logic       next_lock_q;

  assign coh  = ctrl[FPC_COH_POS];
  assign data_cache_line_count = ctrl[FPC_DATA_CACHE_LINE_COUNT_POS +: 2];

  always_comb begin
    unique case (data_cache_line_count)
      2'h0: data_en = 4'h0;
      2'h1: data_en = 4'h1;
      2'h2: data_en = 4'h3;
      2'h3: data_en = 4'hf;
    endcase
  end

  // data lines are never lockable here, so kill_unlocked drops them all
  assign kill_all      = size_changed || (program_cycle && coh);
  assign kill_unlocked = program_cycle && !coh;

  genvar g;
  generate
    for (g = 0; g < FPC_LINES; g++) begin : g_line
      assign fill[g] = timer_done && (fetch_line_q == 2'(g)) &&
                       (!data_q || data_en[g]);
      fpc_line_valid u_line (
        .clk           (clk),
        .reset_n       (reset_n),
        .fill          (fill[g]),
        .lock_in       (lock_q && !data_q),
        .kill_all      (kill_all),
        .kill_unlocked (kill_unlocked),
        .valid         (valid_q[g]),
        .locked        (locked_q[g])
      );
    end
  endgenerate

  // ************************************************************
  // miss handling and wait states
  // ************************************************************
  // the core drops its request one edge after ready, so ready blocks a re-take
  assign miss_start = fetch_req && !fetch_hit && !timer_busy && !fetch_ready;

  always_comb begin
    next_line_q = fetch_line_q;
    next_data_q = data_q;
    next_lock_q = lock_q;
    if (miss_start) begin
      next_line_q = fetch_line;
      next_data_q = fetch_is_data;
      next_lock_q = fetch_lock;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch_line_q <= 2'h0;
      data_q       <= 1'b0;
      lock_q       <= 1'b0;
    end else begin
      fetch_line_q <= next_line_q;
      data_q       <= next_data_q;
      lock_q       <= next_lock_q;
    end
  end

  fpc_wait_timer #(.WIDTH(3)) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (miss_start),
    .waits   (ctrl[FPC_WS_POS +: 3]),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  // ************************************************************
  // registered outputs
  // ************************************************************
  logic next_stall;
  logic next_ready;
  logic next_pref;

  always_comb begin
    // stall from miss until the flash data is returned
    next_stall = miss_start || (timer_busy && !timer_done);
    next_ready = fetch_req && fetch_hit && !timer_busy && !fetch_ready;
    if (timer_done) begin
      next_ready = 1'b1;
    end
    unique case (fpc_pref_e'(ctrl[FPC_PREF_POS +: 2]))
      FPC_PF_OFF:         next_pref = 1'b0;
      FPC_PF_CACHEABLE:   next_pref = fetch_cacheable;
      FPC_PF_UNCACHEABLE: next_pref = !fetch_cacheable;
      FPC_PF_BOTH:        next_pref = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch_stall      <= 1'b0;
      fetch_ready      <= 1'b0;
      prefetch_enable  <= 1'b0;
      line_valid       <= 4'h0;
      data_line_enable <= 4'h0;
    end else begin
      fetch_stall      <= next_stall;
      fetch_ready      <= next_ready;
      prefetch_enable  <= next_pref;
      line_valid       <= valid_q;
      data_line_enable <= data_en;
    end
  end

endmodule // fpc_ctrl

// File: core/fpc_line_valid.sv
// one valid/lock flag pair for a cache line
// assumes invalidate requests arrive as one-cycle pulses
module fpc_line_valid
  import fpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic fill,
  input  wire logic lock_in,
  input  wire logic kill_all,
  input  wire logic kill_unlocked,
  output logic      valid,
  output logic      locked
);
  logic next_valid;
  logic next_locked;

  always_comb begin
    next_valid  = valid;
    next_locked = locked;
    if (kill_all || (kill_unlocked && !locked)) begin
      next_valid  = 1'b0;
      next_locked = 1'b0;
    end else if (fill) begin
      next_valid  = 1'b1;
      next_locked = lock_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      valid  <= 1'b0;
      locked <= 1'b0;
    end else begin
      valid  <= next_valid;
      locked <= next_locked;
    end
  end
endmodule // fpc_line_valid

// File: core/fpc_wait_timer.sv
// down counter that stretches a flash access by the wait-state count
// assumes start is a one-cycle pulse while idle
module fpc_wait_timer
  import fpc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] waits,
  output logic                  busy,
  output logic                  done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_busy;

  // done marks the last wait cycle so the owner can register its answer on it
  assign done = busy && (count == '0);

  always_comb begin
    next_count = count;
    next_busy  = busy;
    if (start) begin
      next_count = waits;
      next_busy  = 1'b1;
    end else if (busy) begin
      if (count == '0) begin
        next_busy = 1'b0;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      busy  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
    end
  end
endmodule // fpc_wait_timer

// File: pkg/fpc_pkg.sv
// package for the flash prefetch/cache control block
// assumes a 32-bit avalon-mm register bus with byte addressing
package fpc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] FPC_CTRL_OFS   = 4'h0;
  localparam logic [3:0] FPC_CLR_OFS    = 4'h4;
  localparam logic [3:0] FPC_SET_OFS    = 4'h8;
  localparam logic [3:0] FPC_INV_OFS    = 4'hc;

  // ************************************************************
  // fields of cache_prefetch_control
  // ************************************************************
  localparam int FPC_COH_POS  = 16;
  localparam int FPC_DATA_CACHE_LINE_COUNT_POS = 8;
  localparam int FPC_PREF_POS = 4;
  localparam int FPC_WS_POS   = 0;
  localparam logic [31:0] FPC_CTRL_MASK  = 32'h0001_0337;
  localparam logic [31:0] FPC_CTRL_RESET = 32'h0000_0007;

  // ************************************************************
  // cache geometry
  // ************************************************************
  localparam int FPC_LINES     = 4;
  localparam int FPC_DATA_LINES = 4;

  typedef enum logic [1:0] {
    FPC_PF_OFF, FPC_PF_CACHEABLE, FPC_PF_UNCACHEABLE, FPC_PF_BOTH
  } fpc_pref_e;

endpackage

// File: tb/fpc_core_model.sv
// core fetch model: one fetch per go pulse, held until the ready pulse
// assumes op = {is_data, cacheable, hit, lock, line[1:0]}
module fpc_core_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [5:0] op,
  input  wire logic       fetch_ready,
  input  wire logic       prefetch_enable,
  output logic            fetch_req,
  output logic [5:0]      fetch_q,
  output logic            busy,
  output logic [7:0]      lat,
  output logic            pe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fetch_req = 1'b0;
    fetch_q = 6'h0;
    busy = 1'b0;
    lat = 8'h0;
    pe = 1'b0;
  end
  always @(posedge clk) begin
    if (busy) begin
      if (fetch_ready) begin
        busy <= 1'b0;
        fetch_req <= 1'b0;
        pe <= prefetch_enable;
        // released qualifiers must not keep their last value
        fetch_q <= ~fetch_q;
      end else begin
        lat <= lat + 8'h01;
      end
    end else if (go) begin
      busy <= 1'b1;
      fetch_req <= 1'b1;
      fetch_q <= op;
      lat <= 8'h0;
    end
  end
endmodule // fpc_core_model

// File: tb/fpc_ctrl_chk.sv
// checker for the cache control ports
// assumes one clock domain, bound to fpc_ctrl
module fpc_ctrl_chk
  import fpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        fetch_req,
  input wire logic        fetch_hit,
  input wire logic        fetch_stall,
  input wire logic        fetch_ready,
  input wire logic [3:0]  data_line_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // properties
  // ******
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  req_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  answer_once_a: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  idle_wait_a: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest) else $error("answer without request");
  unused_zero_a: assert property (
    avs_read && !avs_waitrequest |-> (avs_readdata & ~32'h0001_0337) == 32'h0)
    else $error("unused bits read nonzero");
  dle_code_a: assert property (
    data_line_enable inside {4'h0, 4'h1, 4'h3, 4'hf}) else $error("bad line mask");
  miss_stall_a: assert property (
    $rose(fetch_req) && !fetch_hit |=> fetch_stall) else $error("miss not stalled");
  ready_pulse_a: assert property (
    fetch_ready |=> !fetch_ready) else $error("ready too long");
  stall_bound_a: assert property (
    $rose(fetch_stall) |-> ##[1:9] fetch_ready) else $error("stall too long");
  cover property ($rose(fetch_stall));
  cover property (avs_write && !avs_waitrequest);
  cover property (fetch_ready && !fetch_stall);
endmodule // fpc_ctrl_chk

bind fpc_ctrl fpc_ctrl_chk u_chk (.clk(clk), .reset_n(reset_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .fetch_req(fetch_req), .fetch_hit(fetch_hit), .fetch_stall(fetch_stall),
  .fetch_ready(fetch_ready), .data_line_enable(data_line_enable));

// File: tb/tb.sv
// self-checking bench for fpc_ctrl with a core fetch model
// assumes 20 MHz clock, avalon-mm master tasks below
module tb
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, go = 0;
  logic        program_cycle = 0, avs_waitrequest, fetch_req, fetch_stall;
  logic        fetch_ready, prefetch_enable, busy, pe;
  logic [3:0]  avs_address = 0, avs_byteenable = 4'hf, line_valid, data_line_enable, a;
  logic [31:0] avs_writedata = 0, avs_readdata, q, d, m, seed = 32'hfe86d7f6;
  logic [5:0]  op = 0, fq;
  logic [7:0]  lat;
  int          err_total = 0, checks_done = 0;
  always #25 clk = ~clk;
  fpc_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fetch_req(fetch_req), .fetch_is_data(fq[5]),
    .fetch_cacheable(fq[4]), .fetch_hit(fq[3]), .fetch_line(fq[1:0]), .fetch_lock(fq[2]),
    .fetch_stall(fetch_stall), .fetch_ready(fetch_ready), .program_cycle(program_cycle),
    .prefetch_enable(prefetch_enable), .line_valid(line_valid),
    .data_line_enable(data_line_enable));
  fpc_core_model u_core (.clk(clk), .go(go), .op(op), .fetch_ready(fetch_ready),
    .prefetch_enable(prefetch_enable), .fetch_req(fetch_req), .fetch_q(fq), .busy(busy),
    .lat(lat), .pe(pe));
  // ******
  // helpers
  // ******
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] dle(input logic [1:0] s);
    return (s == 2'h3) ? 32'hf : (s == 2'h2) ? 32'h3 : {31'h0, s[0]};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    for (int n = 0; n < 50 && avs_waitrequest !== 1'b0; n++) @(posedge clk);
    if (avs_waitrequest !== 1'b0) err_total++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fetch(input logic [5:0] o);
    go <= 1'b1;
    op <= o;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic prog();
    program_cycle <= 1'b1;
    @(posedge clk);
    program_cycle <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ******
  // scenarios
  // ******
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1, 4'h6, rnd(), q);
    bus(0, 4'h6, 0, q);
    cmp("unmapped", 32'h0, q);
    bus(0, 4'h0, 0, q);
    cmp("ctrl", 32'h7, q);
    m = 32'h7;
    for (int i = 0; i < 16; i++) begin
      a = 4'(i % 4 * 4);
      d = rnd() & FPC_CTRL_MASK;
      bus(1, a, d, q);
      case (a)
        4'h0: m = d;
        4'h4: m &= ~d;
        4'h8: m |= d;
        default: m ^= d;
      endcase
      bus(0, 4'h0, 0, q);
      cmp("ctrl", m, q);
      cmp("dle", dle(m[9:8]), 32'(data_line_enable));
    end
    for (int i = 0; i < 8; i++) begin
      bus(1, 4'h0, {22'h0, 2'(i), 2'h0, 2'(i), 1'b0, 3'(i)}, q);
      fetch({1'b0, i[2], 2'b00, 2'(i)});
      cmp("lat", 32'(i + 2), 32'(lat));
      cmp("pref", 32'(i[2] ? i[0] : i[1]), 32'(pe));
      cmp("dle", dle(2'(i)), 32'(data_line_enable));
    end
    bus(1, 4'h0, 32'h0000_0300, q);
    fetch(6'b100001);
    fetch(6'b000110);
    fetch(6'b001110);
    prog();
    cmp("lv", 32'h2, 32'(line_valid[2:1]));
    bus(1, 4'h8, 32'h0001_0000, q);
    prog();
    cmp("lv", 32'h0, 32'(line_valid));
    fetch(6'b000110);
    cmp("lv", 32'h4, 32'(line_valid));
    bus(1, 4'h4, 32'h0000_0100, q);
    @(posedge clk);
    cmp("lv", 32'h0, 32'(line_valid));
    end_sim();
  end
endmodule // tb
